// *** dup_pkg.sv ***
// Constants, configuration and status types of the dual serial pin block
package dup_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CHAN_COUNT = 2;
  localparam int DATA_BITS = 8;
  localparam int RX_FIFO_DEPTH = 32;

  // ----------------------------------------------------------------
  // Output port data register bit positions and reset values
  // ----------------------------------------------------------------
  localparam int OP_BIT_RTS_A = 0;
  localparam int OP_BIT_RTS_B = 1;
  localparam int OP_BIT_RX_STAT = 4;
  localparam int OP_BIT_TX_STAT = 6;
  localparam logic [7:0] OP_RESET = 8'h00;
  localparam logic [7:0] BAUD_DIV_RESET = 8'h01;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RXPIN_READY,
    RXPIN_FULL,
    RXPIN_DISCRETE
  } dup_rxpin_e;

  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} dup_rx_state_e;
  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_STOP} dup_tx_state_e;

  typedef struct packed {
    dup_rxpin_e rx_pin_func;
    logic tx_pin_discrete;
    logic [1:0] rts_discrete;
    logic [1:0] cts_enable;
    logic [1:0] ext_clk_sel;
    logic [1:0] tx_enable;
    logic [1:0] rx_enable;
    logic [1:0] loopback;
    logic [7:0] baud_div;
  } dup_cfg_s;

  localparam dup_cfg_s CFG_RESET = '{
    rx_pin_func: RXPIN_READY,
    tx_pin_discrete: 1'b0,
    rts_discrete: 2'h0,
    cts_enable: 2'h0,
    ext_clk_sel: 2'h0,
    tx_enable: 2'h0,
    rx_enable: 2'h0,
    loopback: 2'h0,
    baud_div: BAUD_DIV_RESET
  };

  typedef struct packed {
    logic rx_avail;
    logic rx_full;
    logic tx_ready;
    logic rx_overrun;
    logic rx_frame_err;
  } dup_stat_s;

endpackage

// *** dup_sync.sv ***
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps

module dup_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  initial begin
    if (WIDTH < 1) $error("dup_sync: WIDTH must be at least 1");
  end

  // Meta stage is read by the second stage only
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** dup_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps

module dup_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  // Drain side
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in,
  // Level
  output logic full_out
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("dup_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;

  wire empty = (wr_ptr_r == rd_ptr_r);
  wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
              (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire push = in_valid_in & ~full;
  wire pop = out_ready_in & ~empty;

  assign in_ready_out = ~full;
  assign out_valid_out = ~empty;
  assign full_out = full;
  assign out_data_out = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
    end
  end

endmodule

// *** dup_top.sv ***
// Dual-channel serial pin block: shifters, clock select, muxed pins
`timescale 1ns/1ps

// Behaviour
// - Each channel may take its bit clock from the external serial clock.
// - Receiver samples data on selected clock rising edge, LSB first.
// - Transmitter changes data on selected clock falling edge, LSB first.
// - Transmit line stays mark when disabled, idle or in local loopback.
// - Channel A receive status pin: active low, ready, full or discrete.
// - Ready function drives inverse of receiver-holds-character status.
// - Full function drives inverse of receive-FIFO-full status.
// - Discrete function drives receive status pin from output bit 4.
// - Channel A transmit status pin drives inverse of transmitter ready.
// - Discrete function drives transmit status pin from output bit 6.
// - Each send request pin is modem control output or discrete output.
// - Discrete send request pins follow output bit 1 (B) and bit 0 (A).
// - Active-low send permit input gates transmission when enabled.
module dup_top #(
  parameter int FIFO_DEPTH = dup_pkg::RX_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Configuration and output port data
  input wire dup_pkg::dup_cfg_s cfg_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] op_data_in,
  input wire logic op_wr_in,
  // Clock pins
  input wire logic baud_osc_input_in,
  input wire logic serial_ext_clk_in,
  // Serial lines
  input wire logic rx_line_chan_a_in,
  input wire logic rx_line_chan_b_in,
  output logic tx_line_chan_a_out,
  output logic tx_line_chan_b_out,
  // Status and modem pins
  output logic rx_status_pin_a_n_out,
  output logic tx_status_pin_a_n_out,
  output logic send_request_chan_a_n_out,
  output logic send_request_chan_b_n_out,
  input wire logic send_permit_chan_a_n_in,
  input wire logic send_permit_chan_b_n_in,
  // Transmit characters, index 0 is channel A
  input wire logic [1:0][7:0] tx_data_in,
  input wire logic [1:0] tx_valid_in,
  output logic [1:0] tx_ready_out,
  // Received characters
  output logic [1:0][7:0] rx_data_out,
  output logic [1:0] rx_valid_out,
  input wire logic [1:0] rx_ready_in,
  // Channel status
  output dup_pkg::dup_stat_s [1:0] stat_out
);
  import dup_pkg::*;

  initial begin
    if (FIFO_DEPTH < 2) $error("dup_top: FIFO_DEPTH too small");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pins_s;
  wire [1:0] rx_line_s = pins_s[1:0];
  wire [1:0] permit_n_s = pins_s[3:2];
  wire ext_clk_s = pins_s[4];
  wire osc_s = pins_s[5];

  dup_sync #(.WIDTH(6)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in({baud_osc_input_in, serial_ext_clk_in,
               send_permit_chan_b_n_in, send_permit_chan_a_n_in,
               rx_line_chan_b_in, rx_line_chan_a_in}),
    .sync_out(pins_s)
  );

  // ----------------------------------------------------------------
  // Configuration and output port data registers
  // ----------------------------------------------------------------
  dup_cfg_s cfg_r;
  logic [7:0] op_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_r <= CFG_RESET;
      op_r <= OP_RESET;
    end else begin
      if (cfg_wr_in) cfg_r <= cfg_in;
      if (op_wr_in) op_r <= op_data_in;
    end
  end

  // ----------------------------------------------------------------
  // Internal baud generator
  // ----------------------------------------------------------------
  // Divides oscillator rising edges; a divisor of zero acts as one
  logic osc_prev_r;
  logic [7:0] div_cnt_r;
  logic int_bclk_r;
  wire osc_rise = osc_s & ~osc_prev_r;
  wire [7:0] div_eff = (cfg_r.baud_div == 8'h00) ? 8'h01 : cfg_r.baud_div;
  wire div_wrap = (div_cnt_r + 8'h01) >= div_eff;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      osc_prev_r <= 1'b0;
      div_cnt_r <= 8'h00;
      int_bclk_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_s;
      if (osc_rise) begin
        div_cnt_r <= div_wrap ? 8'h00 : div_cnt_r + 8'h01;
        if (div_wrap) int_bclk_r <= ~int_bclk_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic [1:0] tx_pin_nxt;
  logic [1:0] tx_busy;

  for (genvar ch = 0; ch < CHAN_COUNT; ch++) begin : g_chan
    logic bclk_prev_r;
    dup_rx_state_e rx_st_r;
    logic [2:0] rx_cnt_r;
    logic [7:0] rx_sh_r;
    logic [7:0] rx_hold_r;
    logic rx_hold_full_r;
    logic rx_overrun_r;
    logic rx_frame_err_r;
    dup_tx_state_e tx_st_r;
    logic [2:0] tx_cnt_r;
    logic [7:0] tx_sh_r;
    logic tx_line_r;
    logic [7:0] tx_hold_r;
    logic tx_hold_full_r;
    logic fifo_in_ready;
    logic fifo_full;

    // Clock source select and edge detect
    wire bclk = cfg_r.ext_clk_sel[ch] ? ext_clk_s : int_bclk_r;
    wire rise = bclk & ~bclk_prev_r;
    wire fall = ~bclk & bclk_prev_r;

    // Receive decode
    wire rx_bit = cfg_r.loopback[ch] ? tx_line_r : rx_line_s[ch];
    wire rx_last = (rx_cnt_r == LAST_BIT_IDX);
    wire rx_done = rise & (rx_st_r == RX_STOP) & rx_bit;
    wire rx_ferr = rise & (rx_st_r == RX_STOP) & ~rx_bit;
    // A new character is dropped if the holding stage cannot drain
    wire rx_ovr = rx_done & rx_hold_full_r & ~fifo_in_ready;
    wire rx_load = rx_done & ~rx_ovr;
    wire rx_hold_nxt = rx_load | (rx_hold_full_r & ~fifo_in_ready);

    // Transmit decode
    wire permit_ok = ~cfg_r.cts_enable[ch] | ~permit_n_s[ch];
    wire tx_take = fall & (tx_st_r == TX_IDLE) & tx_hold_full_r &
                   cfg_r.tx_enable[ch] & permit_ok;
    wire tx_accept = tx_valid_in[ch] & ~tx_hold_full_r;
    wire tx_last = (tx_cnt_r == LAST_BIT_IDX);
    wire tx_mark = ~cfg_r.tx_enable[ch] | cfg_r.loopback[ch];

    assign tx_ready_out[ch] = ~tx_hold_full_r;
    assign tx_pin_nxt[ch] = tx_mark | tx_line_r;
    assign tx_busy[ch] = tx_hold_full_r | (tx_st_r != TX_IDLE);

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        bclk_prev_r <= 1'b0;
      end else begin
        bclk_prev_r <= bclk;
      end
    end

    // Receiver: samples on rising edges, LSB first
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        rx_st_r <= RX_IDLE;
        rx_cnt_r <= 3'h0;
        rx_sh_r <= 8'h00;
      end else if (rise) begin
        unique case (rx_st_r)
          RX_IDLE: begin
            if (cfg_r.rx_enable[ch] && !rx_bit) rx_st_r <= RX_DATA;
            rx_cnt_r <= 3'h0;
          end
          RX_DATA: begin
            rx_sh_r <= {rx_bit, rx_sh_r[7:1]};
            rx_cnt_r <= rx_cnt_r + 3'h1;
            if (rx_last) rx_st_r <= RX_STOP;
          end
          RX_STOP: begin
            rx_st_r <= RX_IDLE;
          end
          default: begin
            rx_st_r <= RX_IDLE;
          end
        endcase
      end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        rx_hold_r <= 8'h00;
        rx_hold_full_r <= 1'b0;
        rx_overrun_r <= 1'b0;
        rx_frame_err_r <= 1'b0;
      end else begin
        if (rx_load) rx_hold_r <= rx_sh_r;
        rx_hold_full_r <= rx_hold_nxt;
        rx_overrun_r <= rx_ovr;
        rx_frame_err_r <= rx_ferr;
      end
    end

    dup_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .in_data_in(rx_hold_r),
      .in_valid_in(rx_hold_full_r),
      .in_ready_out(fifo_in_ready),
      .out_data_out(rx_data_out[ch]),
      .out_valid_out(rx_valid_out[ch]),
      .out_ready_in(rx_ready_in[ch]),
      .full_out(fifo_full)
    );

    // Transmit holding register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        tx_hold_r <= 8'h00;
        tx_hold_full_r <= 1'b0;
      end else begin
        if (tx_accept) tx_hold_r <= tx_data_in[ch];
        tx_hold_full_r <= tx_accept | (tx_hold_full_r & ~tx_take);
      end
    end

    // Transmitter: line changes on falling edges only, LSB first
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        tx_st_r <= TX_IDLE;
        tx_cnt_r <= 3'h0;
        tx_sh_r <= 8'h00;
        tx_line_r <= 1'b1;
      end else if (fall) begin
        unique case (tx_st_r)
          TX_IDLE: begin
            tx_cnt_r <= 3'h0;
            if (tx_take) begin
              tx_line_r <= 1'b0;
              tx_sh_r <= tx_hold_r;
              tx_st_r <= TX_DATA;
            end
          end
          TX_DATA: begin
            tx_line_r <= tx_sh_r[0];
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            tx_cnt_r <= tx_cnt_r + 3'h1;
            if (tx_last) tx_st_r <= TX_STOP;
          end
          TX_STOP: begin
            tx_line_r <= 1'b1;
            tx_st_r <= TX_IDLE;
          end
          default: begin
            tx_st_r <= TX_IDLE;
          end
        endcase
      end
    end

    assign stat_out[ch] = '{
      rx_avail: rx_valid_out[ch],
      rx_full: fifo_full,
      tx_ready: ~tx_hold_full_r,
      rx_overrun: rx_overrun_r,
      rx_frame_err: rx_frame_err_r
    };
  end

  // ----------------------------------------------------------------
  // Multiplexed pin functions
  // ----------------------------------------------------------------
  wire rx_pin_ready = cfg_r.rx_pin_func == RXPIN_READY;
  wire rx_pin_full = cfg_r.rx_pin_func == RXPIN_FULL;
  wire rx_pin_disc = cfg_r.rx_pin_func == RXPIN_DISCRETE;
  // Unused select code parks the pin inactive high
  wire rx_stat_nxt =
    rx_pin_ready ? ~stat_out[0].rx_avail :
    rx_pin_full ? ~stat_out[0].rx_full :
    rx_pin_disc ? op_r[OP_BIT_RX_STAT] :
    1'b1;
  wire tx_stat_nxt = cfg_r.tx_pin_discrete ? op_r[OP_BIT_TX_STAT]
                                           : ~stat_out[0].tx_ready;
  wire rts_a_nxt = cfg_r.rts_discrete[0] ? op_r[OP_BIT_RTS_A]
                                         : ~tx_busy[0];
  wire rts_b_nxt = cfg_r.rts_discrete[1] ? op_r[OP_BIT_RTS_B]
                                         : ~tx_busy[1];

  // Pins are registered so no decode glitch reaches the board
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tx_line_chan_a_out <= 1'b1;
      tx_line_chan_b_out <= 1'b1;
      rx_status_pin_a_n_out <= 1'b1;
      tx_status_pin_a_n_out <= 1'b1;
      send_request_chan_a_n_out <= 1'b1;
      send_request_chan_b_n_out <= 1'b1;
    end else begin
      tx_line_chan_a_out <= tx_pin_nxt[0];
      tx_line_chan_b_out <= tx_pin_nxt[1];
      rx_status_pin_a_n_out <= rx_stat_nxt;
      tx_status_pin_a_n_out <= tx_stat_nxt;
      send_request_chan_a_n_out <= rts_a_nxt;
      send_request_chan_b_n_out <= rts_b_nxt;
    end
  end

endmodule

// *** dup_top_assertions.sv ***
// Pin-level assertions for the dual serial pin block
`timescale 1ns/1ps

module dup_top_checker #(
  parameter int FIFO_DEPTH = 32
) (
  // Clock, reset, configuration
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire dup_pkg::dup_cfg_s cfg_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] op_data_in,
  input wire logic op_wr_in,
  // Pins
  input wire logic serial_ext_clk_in,
  input wire logic tx_line_chan_a_out,
  input wire logic tx_line_chan_b_out,
  input wire logic rx_status_pin_a_n_out,
  input wire logic tx_status_pin_a_n_out,
  input wire logic send_request_chan_a_n_out,
  input wire logic send_request_chan_b_n_out,
  // Handshakes and status
  input wire logic [1:0] tx_ready_out,
  input wire logic [1:0] rx_valid_out,
  input wire dup_pkg::dup_stat_s [1:0] stat_out
);
  import dup_pkg::*;
  // Mirror of the written words, pins lag them by one edge
  dup_cfg_s cfg_q;
  logic [7:0] op_q;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_q <= CFG_RESET;
      op_q <= OP_RESET;
    end else begin
      if (cfg_wr_in) cfg_q <= cfg_in;
      if (op_wr_in) op_q <= op_data_in;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  a_tx_mark: assert property (
    (cfg_q.loopback[1] || !cfg_q.tx_enable[1])[*2] |-> tx_line_chan_b_out)
    else $error("line B left mark");
  a_tx_fall_edge: assert property (
    tx_line_chan_a_out != $past(tx_line_chan_a_out) && cfg_q.ext_clk_sel[0]
    |-> !$past(serial_ext_clk_in, 2)) else $error("line A moved off fall");
  a_rxpin_ready: assert property (
    cfg_q.rx_pin_func == RXPIN_READY |=>
    rx_status_pin_a_n_out == !$past(rx_valid_out[0])) else $error("ready pin");
  a_rxpin_full: assert property (
    cfg_q.rx_pin_func == RXPIN_FULL |=>
    rx_status_pin_a_n_out == !$past(stat_out[0].rx_full)) else $error("full pin");
  a_rxpin_discrete: assert property (
    cfg_q.rx_pin_func == RXPIN_DISCRETE |=>
    rx_status_pin_a_n_out == $past(op_q[OP_BIT_RX_STAT])) else $error("rx op");
  a_txpin_ready: assert property (
    !cfg_q.tx_pin_discrete |=>
    tx_status_pin_a_n_out == !$past(tx_ready_out[0])) else $error("tx pin");
  a_txpin_discrete: assert property (
    cfg_q.tx_pin_discrete |=>
    tx_status_pin_a_n_out == $past(op_q[OP_BIT_TX_STAT])) else $error("tx op");
  a_rts_modem: assert property (
    $fell(tx_ready_out[0]) && !cfg_q.rts_discrete[0] |=>
    !send_request_chan_a_n_out) else $error("send request A late");
  a_rts_discrete: assert property (
    cfg_q.rts_discrete[1] |=>
    send_request_chan_b_n_out == $past(op_q[OP_BIT_RTS_B])) else $error("rts B");
  c_overrun: cover property (stat_out[0].rx_overrun);
  c_frame_err: cover property (stat_out[0].rx_frame_err);
  c_tx_start: cover property ($fell(tx_line_chan_a_out));
endmodule

bind dup_top dup_top_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cfg_in(cfg_in),
  .cfg_wr_in(cfg_wr_in), .op_data_in(op_data_in), .op_wr_in(op_wr_in),
  .serial_ext_clk_in(serial_ext_clk_in),
  .tx_line_chan_a_out(tx_line_chan_a_out),
  .tx_line_chan_b_out(tx_line_chan_b_out),
  .rx_status_pin_a_n_out(rx_status_pin_a_n_out),
  .tx_status_pin_a_n_out(tx_status_pin_a_n_out),
  .send_request_chan_a_n_out(send_request_chan_a_n_out),
  .send_request_chan_b_n_out(send_request_chan_b_n_out),
  .tx_ready_out(tx_ready_out), .rx_valid_out(rx_valid_out),
  .stat_out(stat_out));

// *** dup_far_end.sv ***
// Behavioural remote serial terminal facing both channels
`timescale 1ns/1ps

module dup_far_end (
  // Toward the block
  output logic sclk_out,
  output logic [1:0] rx_out,
  output logic [1:0] permit_n_out,
  // From the block
  input wire logic [1:0] tx_in
);
  initial begin
    sclk_out = 1'b0;
    rx_out = 2'h3;
    permit_n_out = 2'h0;
  end

  // Clock stands low between frames, so nothing moves outside them
  task automatic frame(input logic [7:0] da, input logic [7:0] db,
      input logic bad, output logic [8:0] ga, output logic [8:0] gb);
    logic [1:0][9:0] f;
    logic [1:0][8:0] g;
    int n [2];
    f[0] = {~bad, da, 1'b0};
    f[1] = {~bad, db, 1'b0};
    g = '0;
    n = '{0, 0};
    #7;
    for (int i = 0; i < 13; i++) begin
      for (int c = 0; c < 2; c++) begin
        rx_out[c] = (i < 10) ? f[c][i] : 1'b1;
      end
      #200 sclk_out = 1'b1;
      for (int c = 0; c < 2; c++) begin
        if (n[c] == 0 && tx_in[c] === 1'b0) begin
          n[c] = 1;
          g[c][8] = 1'b1;
        end else if (n[c] > 0 && n[c] < 9) begin
          g[c][n[c] - 1] = tx_in[c];
          n[c]++;
        end
      end
      #200 sclk_out = 1'b0;
    end
    ga = g[0];
    gb = g[1];
  endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the dual serial pin block
`timescale 1ns/1ps

module testbench;
  import dup_pkg::*;
  logic clk_sys_in, rst_in, cfg_wr_in, op_wr_in, ferr, ovr, osc;
  dup_cfg_s cfg_in, c;
  logic [7:0] op_data_in;
  logic [1:0] tx_valid_in, rx_ready_in;
  logic [1:0][7:0] tx_data_in;
  wire logic [1:0][7:0] rx_data_out;
  wire logic [1:0] rx_l, tx_l, perm_n, tx_ready_out, rx_valid_out;
  wire logic sclk, rx_pin_n, tx_pin_n, rts_a_n, rts_b_n;
  wire dup_stat_s [1:0] stat_out;
  logic [8:0] ga, gb;
  logic [7:0] pat [4] = '{8'h53, 8'h00, 8'h41, 8'h12};
  int n_fail, checks;

  dup_top dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cfg_in(cfg_in),
    .cfg_wr_in(cfg_wr_in), .op_data_in(op_data_in), .op_wr_in(op_wr_in),
    .baud_osc_input_in(osc), .serial_ext_clk_in(sclk),
    .rx_line_chan_a_in(rx_l[0]), .rx_line_chan_b_in(rx_l[1]),
    .tx_line_chan_a_out(tx_l[0]), .tx_line_chan_b_out(tx_l[1]),
    .rx_status_pin_a_n_out(rx_pin_n), .tx_status_pin_a_n_out(tx_pin_n),
    .send_request_chan_a_n_out(rts_a_n),
    .send_request_chan_b_n_out(rts_b_n),
    .send_permit_chan_a_n_in(perm_n[0]), .send_permit_chan_b_n_in(perm_n[1]),
    .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
    .tx_ready_out(tx_ready_out), .rx_data_out(rx_data_out),
    .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in),
    .stat_out(stat_out));

  dup_far_end u_far (.sclk_out(sclk), .rx_out(rx_l), .permit_n_out(perm_n),
    .tx_in(tx_l));

  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // Oscillator pin at half the system clock feeds the baud divider
  always @(posedge clk_sys_in) begin
    osc <= ~osc;
  end

  // Status flags are one-cycle pulses, so latch them
  always @(posedge clk_sys_in) begin
    if (stat_out[0].rx_frame_err === 1'b1) ferr <= 1'b1;
    if (stat_out[0].rx_overrun === 1'b1) ovr <= 1'b1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Config and port word together; pins settle two edges after
  task automatic wr(input dup_cfg_s v, input logic [7:0] o);
    @(posedge clk_sys_in);
    cfg_in <= v;
    op_data_in <= o;
    cfg_wr_in <= 1'b1;
    op_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    cfg_wr_in <= 1'b0;
    op_wr_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask

  task automatic send(input int ch, input logic [7:0] d);
    int i;
    @(posedge clk_sys_in);
    tx_data_in[ch] <= d;
    tx_valid_in[ch] <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge clk_sys_in);
      if (tx_ready_out[ch] === 1'b1) break;
    end
    if (i == 40) begin
      n_fail++;
      give_verdict();
    end
    @(posedge clk_sys_in);
    tx_valid_in[ch] <= 1'b0;
  endtask

  task automatic pop(input int ch, input logic [7:0] d);
    @(negedge clk_sys_in);
    chk({rx_valid_out[ch], rx_data_out[ch]}, {1'b1, d});
    @(posedge clk_sys_in);
    rx_ready_in[ch] <= 1'b1;
    @(posedge clk_sys_in);
    rx_ready_in[ch] <= 1'b0;
  endtask

  initial begin
    n_fail = 0;
    checks = 0;
    ferr = 1'b0;
    ovr = 1'b0;
    osc = 1'b0;
    rst_in = 1'b1;
    cfg_in = CFG_RESET;
    cfg_wr_in = 1'b0;
    op_data_in = 8'h00;
    op_wr_in = 1'b0;
    tx_data_in = '0;
    tx_valid_in = 2'h0;
    rx_ready_in = 2'h0;
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (2) @(negedge clk_sys_in);
    chk({tx_l, rx_pin_n, tx_pin_n, rts_a_n, rts_b_n}, 6'h3B);
    c = CFG_RESET;
    c.rx_pin_func = RXPIN_DISCRETE;
    c.tx_pin_discrete = 1'b1;
    c.rts_discrete = 2'h3;
    for (int k = 0; k < 4; k++) begin
      wr(c, pat[k]);
      chk({rx_pin_n, tx_pin_n}, {pat[k][4], pat[k][6]});
      chk({rts_b_n, rts_a_n}, pat[k][1:0]);
    end
    // --------------------------------
    // Frames on the external bit clock
    // --------------------------------
    c = CFG_RESET;
    c.ext_clk_sel = 2'h3;
    c.tx_enable = 2'h3;
    c.rx_enable = 2'h3;
    c.cts_enable = 2'h3;
    wr(c, 8'h00);
    u_far.permit_n_out = 2'h3;
    send(0, 8'hA5);
    send(1, 8'h3C);
    repeat (3) @(negedge clk_sys_in);
    chk({rts_b_n, rts_a_n, tx_pin_n}, 3'h1);
    u_far.frame(8'h96, 8'h01, 1'b0, ga, gb);
    chk({ga[8], gb[8], rx_pin_n}, 3'h0);
    pop(0, 8'h96);
    pop(1, 8'h01);
    u_far.permit_n_out = 2'h0;
    u_far.frame(8'h00, 8'hFF, 1'b0, ga, gb);
    chk({ga, gb}, {9'h1A5, 9'h13C});
    pop(0, 8'h00);
    pop(1, 8'hFF);
    u_far.frame(8'h77, 8'h77, 1'b1, ga, gb);
    @(negedge clk_sys_in);
    chk({ferr, rx_valid_out}, 3'h4);
    c.loopback = 2'h2;
    wr(c, 8'h00);
    send(1, 8'hC3);
    u_far.frame(8'h11, 8'h5A, 1'b0, ga, gb);
    chk(gb[8], 1'b0);
    pop(1, 8'hC3);
    pop(0, 8'h11);
    // --------------------------------
    // Receive FIFO fill and drain
    // --------------------------------
    c.loopback = 2'h0;
    c.rx_pin_func = RXPIN_FULL;
    wr(c, 8'h00);
    for (int k = 0; k < 34; k++) begin
      u_far.frame(k[7:0], 8'h00, 1'b0, ga, gb);
      if (k == 30) chk(rx_pin_n, 1'b1);
    end
    chk({rx_pin_n, ovr}, 2'h1);
    for (int k = 0; k < 33; k++) pop(0, k[7:0]);
    @(negedge clk_sys_in);
    chk({rx_pin_n, rx_valid_out[0]}, 2'h2);
    // --------------------------------
    // Internal baud generator, loopback on A
    // --------------------------------
    c.ext_clk_sel = 2'h2;
    c.loopback = 2'h1;
    c.baud_div = 8'h02;
    wr(c, 8'h00);
    send(0, 8'h6D);
    repeat (200) @(negedge clk_sys_in);
    pop(0, 8'h6D);
    chk(tx_l[0], 1'b1);
    give_verdict();
  end
endmodule
